// file: inc/dof_pkg.sv
// Purpose: shared constants and types for the drive digital output block
// Assumes: 40 MHz mclk, registers on Avalon-MM, one aligned word each
// Notes:   byte addresses below; codes select what each output or input does
package dof_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OUT_SEL = 8'h00;
  localparam logic [7:0] OFS_ZS_THR = 8'h04;
  localparam logic [7:0] OFS_ZS_TIME = 8'h08;
  localparam logic [7:0] OFS_DIV_SHIFT = 8'h0C;
  localparam logic [7:0] OFS_PULSE_MS = 8'h10;
  localparam logic [7:0] OFS_FIELDBUS = 8'h14;
  localparam logic [7:0] OFS_CTRL_TYPE = 8'h18;
  localparam logic [7:0] OFS_IN_SEL = 8'h1C;
  localparam logic [7:0] OFS_OUT_STATE = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] ZS_THR_RST = 16'h000A;
  localparam logic [15:0] ZS_TIME_RST = 16'h00C8;
  localparam logic [4:0] DIV_SHIFT_RST = 5'h02;
  localparam logic [15:0] PULSE_MS_RST = 16'h000A;
  localparam int OUT_SEL_W = 4;
  localparam int IN_SEL_W = 3;
  localparam int IRQ_W = 4;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_HOMED = 1;
  localparam int IRQ_POSPULSE = 2;
  localparam int IRQ_REJECT = 3;

  // ----------------------------------------------------------------
  // output function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_OFF = 4'h0;
  localparam logic [3:0] FN_TORQUE = 4'h1;
  localparam logic [3:0] FN_OVERLOAD = 4'h2;
  localparam logic [3:0] FN_ZERO_SPEED = 4'h3;
  localparam logic [3:0] FN_TARGET = 4'h4;
  localparam logic [3:0] FN_BRAKE = 4'h5;
  localparam logic [3:0] FN_HEALTHY = 4'h6;
  localparam logic [3:0] FN_POS_FREQ = 4'h7;
  localparam logic [3:0] FN_POS_PULSE = 4'h8;
  localparam logic [3:0] FN_HOMED = 4'h9;
  localparam logic [3:0] FN_FIELDBUS = 4'hA;

  // ----------------------------------------------------------------
  // input function codes and control types
  // ----------------------------------------------------------------
  localparam logic [2:0] IN_NONE = 3'h0;
  localparam logic [2:0] IN_VEL_PLUS = 3'h1;
  localparam logic [2:0] IN_VEL_MINUS = 3'h2;
  localparam logic [2:0] IN_PROBE1 = 3'h3;
  localparam logic [2:0] IN_PROBE2 = 3'h4;
  localparam logic [2:0] CT_SPEED = 3'h0;
  localparam logic [2:0] CT_TORQUE = 3'h1;
  localparam logic [2:0] CT_EAXIS = 3'h2;
  localparam logic [2:0] CT_POSITION = 3'h3;
  localparam logic [2:0] CT_CAM = 3'h4;
  localparam logic [2:0] CT_PRESS = 3'h5;
  localparam logic [2:0] CT_FIELDBUS = 3'h6;

  typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} dof_bus_t;

  // live drive status feeding the output sources
  typedef struct packed {
    logic torqueLimit;
    logic ratedTorque;
    logic thermalOverloadAlarm;
    logic anyAlarm;
    logic brakeCmd;
    logic posReached;
    logic homingDone;
    logic camDone;
    logic pressureReached;
    logic inputStartMode;
    logic homingRequest;
    logic [15:0] speedAbs;
    logic [15:0] posInTurn;
  } dof_drive_t;

  // which inputs may carry which function under a control type
  function automatic logic dof_in_allowed(input logic [2:0] fn, input logic [2:0] ctrl,
                                          input int idx);
    logic shiftCtl;
    shiftCtl = (ctrl == CT_EAXIS) || (ctrl == CT_CAM);
    case (fn)
      IN_NONE: dof_in_allowed = 1'b1;
      IN_VEL_PLUS: dof_in_allowed = shiftCtl && (idx == 5);
      IN_VEL_MINUS: dof_in_allowed = shiftCtl && (idx == 6);
      IN_PROBE1, IN_PROBE2: dof_in_allowed = (ctrl == CT_FIELDBUS) && (idx == 1 || idx == 5);
      default: dof_in_allowed = 1'b0;
    endcase
  endfunction : dof_in_allowed

  function automatic logic [31:0] dof_merge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    dof_merge = (old & ~m) | (wr & m);
  endfunction : dof_merge

endpackage : dof_pkg

// file: hdl/dof_outputs.sv
// Purpose: digital output function routing and input function decode of a drive
// Assumes: drive status inputs synchronous to mclk; one register word per offset
// Notes:   every output and the bus answer come from the single state register
//
// How it works
// - torque output high at rated torque or limit
// - overload output high on thermal overload alarm
// - zero speed threshold and time are configurable
// - target output on position, homing, cam, pressure
// - healthy output high, low on any alarm
// - square wave: position in turn over divider
// - resolution from encoder; incremental lines times four
// - timed pulse on position reached, input-start only
// - homing flag latched until next homing request
// - any output can follow a fieldbus bit
// - output selection works in every mode
// - inputs accept only functions of control type
// - velocity shift inputs command speed phase shift
// - probe inputs act as capture triggers
// - ports are active at high level
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dof_outputs #(
  parameter int NUM_OUT = 2,
  parameter int NUM_IN = 8,
  parameter int MS_CYC = dof_pkg::MS_CYCLES,
  parameter bit ABS_ENCODER = 1'b0,
  parameter int ENC_LINES = 2500,
  parameter int ABS_BITS = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // drive side
  input wire dof_pkg::dof_drive_t drv,
  input wire logic [NUM_IN-1:0] digIn,
  // ports and decoded inputs
  output logic [NUM_OUT-1:0] portOut,
  output logic velShiftPlus,
  output logic velShiftMinus,
  output logic probe1,
  output logic probe2
);
  import dof_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int FEEDBACK_RESOLUTION = ABS_ENCODER ? (1 << ABS_BITS) : ENC_LINES * 4;

  typedef struct packed {
    dof_bus_t busSt;
    logic waitReq;
    logic [31:0] readData;
    logic [NUM_OUT*OUT_SEL_W-1:0] outSel;
    logic [15:0] zsThr;
    logic [15:0] zsTime;
    logic [4:0] divShift;
    logic [15:0] pulseMs;
    logic [NUM_OUT-1:0] fieldbus;
    logic [2:0] ctrlType;
    logic [NUM_IN*IN_SEL_W-1:0] inSel;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic irq;
    logic [MSW-1:0] msCnt;
    logic [15:0] zsCnt;
    logic zeroSpeed;
    logic homeLatch;
    logic [15:0] pulseCnt;
    logic prevPosReached;
    logic prevHoming;
    logic prevAlarm;
    logic [NUM_OUT-1:0] portOut;
    logic velPlus;
    logic velMinus;
    logic probe1;
    logic probe2;
  } dof_state_t;

  dof_state_t q;
  dof_state_t d;
  logic msTick;
  logic posRise;
  logic homeRise;
  logic reject;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clrBits;
  logic [31:0] rdMux;
  logic [31:0] wrWord;
  logic posBit;
  logic [3:0] fn;
  logic [2:0] ifn;

  // bit n toggles every 2^n counts
  assign posBit = drv.posInTurn[q.divShift[3:0]];

  always_comb begin
    d = q;
    clrBits = '0;
    reject = 1'b0;
    fn = FN_OFF;
    ifn = IN_NONE;
    msTick = (q.msCnt == MSW'(MS_CYC - 1));
    d.msCnt = msTick ? '0 : q.msCnt + 1'b1;
    posRise = drv.posReached && !q.prevPosReached;
    homeRise = drv.homingDone && !q.prevHoming;
    d.prevPosReached = drv.posReached;
    d.prevHoming = drv.homingDone;
    d.prevAlarm = drv.anyAlarm;

    // ----------------------------------------------------------------
    // zero speed qualification
    // ----------------------------------------------------------------
    // continuous time at or below threshold
    if (drv.speedAbs > q.zsThr) begin
      d.zsCnt = '0;
      d.zeroSpeed = 1'b0;
    end else if (q.zsCnt >= q.zsTime) begin
      d.zeroSpeed = 1'b1;
    end else if (msTick) begin
      d.zsCnt = q.zsCnt + 1'b1;
    end

    // ----------------------------------------------------------------
    // homing latch and position pulse
    // ----------------------------------------------------------------
    // set beats request clear
    d.homeLatch = homeRise || (q.homeLatch && !drv.homingRequest);
    if (posRise && drv.inputStartMode) begin
      d.pulseCnt = q.pulseMs;
    end else if (q.pulseCnt != 16'h0000 && msTick) begin
      d.pulseCnt = q.pulseCnt - 1'b1;
    end

    // ----------------------------------------------------------------
    // output routing
    // ----------------------------------------------------------------
    for (int i = 0; i < NUM_OUT; i++) begin
      fn = q.outSel[i*OUT_SEL_W +: OUT_SEL_W];
      // one source per port, no mode gating
      case (fn)
        FN_TORQUE: d.portOut[i] = drv.torqueLimit || drv.ratedTorque;
        FN_OVERLOAD: d.portOut[i] = drv.thermalOverloadAlarm;
        FN_ZERO_SPEED: d.portOut[i] = q.zeroSpeed;
        FN_TARGET: d.portOut[i] = drv.posReached || drv.homingDone || drv.camDone ||
                                  drv.pressureReached;
        FN_BRAKE: d.portOut[i] = drv.brakeCmd;
        FN_HEALTHY: d.portOut[i] = !drv.anyAlarm;
        FN_POS_FREQ: d.portOut[i] = posBit;
        FN_POS_PULSE: d.portOut[i] = q.pulseCnt != 16'h0000;
        FN_HOMED: d.portOut[i] = q.homeLatch;
        FN_FIELDBUS: d.portOut[i] = q.fieldbus[i];
        default: d.portOut[i] = 1'b0;
      endcase
    end

    // ----------------------------------------------------------------
    // input function decode
    // ----------------------------------------------------------------
    d.velPlus = 1'b0;
    d.velMinus = 1'b0;
    d.probe1 = 1'b0;
    d.probe2 = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      ifn = q.inSel[i*IN_SEL_W +: IN_SEL_W];
      if (!dof_in_allowed(ifn, q.ctrlType, i)) begin
        reject = 1'b1;
      end else begin
        case (ifn)
          IN_VEL_PLUS: d.velPlus = d.velPlus || digIn[i];
          IN_VEL_MINUS: d.velMinus = d.velMinus || digIn[i];
          IN_PROBE1: d.probe1 = d.probe1 || digIn[i];
          IN_PROBE2: d.probe2 = d.probe2 || digIn[i];
          default: ;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    rdMux = 32'h0000_0000;
    case (avs_address)
      OFS_OUT_SEL: rdMux[NUM_OUT*OUT_SEL_W-1:0] = q.outSel;
      OFS_ZS_THR: rdMux[15:0] = q.zsThr;
      OFS_ZS_TIME: rdMux[15:0] = q.zsTime;
      OFS_DIV_SHIFT: rdMux[4:0] = q.divShift;
      OFS_PULSE_MS: rdMux[15:0] = q.pulseMs;
      OFS_FIELDBUS: rdMux[NUM_OUT-1:0] = q.fieldbus;
      OFS_CTRL_TYPE: rdMux[2:0] = q.ctrlType;
      OFS_IN_SEL: rdMux[NUM_IN*IN_SEL_W-1:0] = q.inSel;
      OFS_OUT_STATE: rdMux[NUM_OUT+1:0] = {q.homeLatch, q.zeroSpeed, q.portOut};
      OFS_IRQ_STAT: rdMux[IRQ_W-1:0] = q.irqStat;
      OFS_IRQ_MASK: rdMux[IRQ_W-1:0] = q.irqMask;
      default: rdMux = 32'h0000_0000;
    endcase
    wrWord = dof_merge(rdMux, avs_writedata, avs_byteenable);
    case (q.busSt)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          d.busSt = BUS_ACK;
          d.waitReq = 1'b0;
          d.readData = avs_read ? rdMux : 32'h0000_0000;
        end
      end
      BUS_ACK: begin
        d.busSt = BUS_IDLE;
        d.waitReq = 1'b1;
        // only bits actually returned are cleared, so late events survive
        if (avs_read && avs_address == OFS_IRQ_STAT) begin
          clrBits = q.readData[IRQ_W-1:0];
        end
        if (avs_write) begin
          case (avs_address)
            OFS_OUT_SEL: d.outSel = wrWord[NUM_OUT*OUT_SEL_W-1:0];
            OFS_ZS_THR: d.zsThr = wrWord[15:0];
            OFS_ZS_TIME: d.zsTime = wrWord[15:0];
            OFS_DIV_SHIFT: d.divShift = {1'b0, wrWord[3:0]};
            OFS_PULSE_MS: d.pulseMs = wrWord[15:0];
            OFS_FIELDBUS: d.fieldbus = wrWord[NUM_OUT-1:0];
            OFS_CTRL_TYPE: d.ctrlType = wrWord[2:0];
            OFS_IN_SEL: d.inSel = wrWord[NUM_IN*IN_SEL_W-1:0];
            OFS_IRQ_MASK: d.irqMask = wrWord[IRQ_W-1:0];
            default: ;
          endcase
        end
      end
      default: begin
        d.busSt = BUS_IDLE;
        d.waitReq = 1'b1;
      end
    endcase

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    events = '0;
    events[IRQ_ALARM] = drv.anyAlarm && !q.prevAlarm;
    events[IRQ_HOMED] = homeRise;
    events[IRQ_POSPULSE] = posRise && drv.inputStartMode;
    events[IRQ_REJECT] = reject;
    d.irqStat = (q.irqStat & ~clrBits) | events;
    d.irq = |(d.irqStat & q.irqMask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.busSt <= BUS_IDLE;
      q.waitReq <= 1'b1;
      q.zsThr <= ZS_THR_RST;
      q.zsTime <= ZS_TIME_RST;
      q.divShift <= DIV_SHIFT_RST;
      q.pulseMs <= PULSE_MS_RST;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata = q.readData;
  assign avs_waitrequest = q.waitReq;
  assign irq = q.irq;
  assign portOut = q.portOut;
  assign velShiftPlus = q.velPlus;
  assign velShiftMinus = q.velMinus;
  assign probe1 = q.probe1;
  assign probe2 = q.probe2;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  wire [3:0] sel0 = q.outSel[OUT_SEL_W-1:0];

  sequence busTaken;
    (avs_read || avs_write) && q.waitReq && q.busSt == BUS_IDLE;
  endsequence
  sequence busAnswer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (busTaken |=> busAnswer)
    else $error("bus answer not one cycle");
  torque_out_a: assert property (
    sel0 == FN_TORQUE && (drv.torqueLimit || drv.ratedTorque) |=> portOut[0])
    else $error("torque output low");
  overload_out_a: assert property (
    sel0 == FN_OVERLOAD |=> portOut[0] == $past(drv.thermalOverloadAlarm))
    else $error("overload output wrong");
  zero_drop_a: assert property (
    drv.speedAbs > q.zsThr |=> !q.zeroSpeed && q.zsCnt == 16'h0000)
    else $error("zero speed kept above threshold");
  target_out_a: assert property (
    sel0 == FN_TARGET && drv.camDone |=> portOut[0])
    else $error("target output low");
  healthy_out_a: assert property (
    sel0 == FN_HEALTHY |=> portOut[0] == !$past(drv.anyAlarm))
    else $error("healthy output wrong");
  pos_freq_a: assert property (
    sel0 == FN_POS_FREQ |=> portOut[0] == $past(posBit))
    else $error("square wave wrong");
  pulse_load_a: assert property (
    drv.posReached && !q.prevPosReached && drv.inputStartMode
      |=> q.pulseCnt == $past(q.pulseMs))
    else $error("pulse not loaded");
  homing_hold_a: assert property (
    q.homeLatch && !drv.homingRequest |=> q.homeLatch[*2] or (q.homeLatch ##1 1'b1))
    else $error("homing flag dropped");
  fieldbus_out_a: assert property (
    sel0 == FN_FIELDBUS |=> portOut[0] == $past(q.fieldbus[0]))
    else $error("fieldbus output wrong");
  input_reject_a: assert property (
    reject |=> q.irqStat[IRQ_REJECT] ##1 q.irqStat[IRQ_REJECT] || $past(clrBits[IRQ_REJECT]))
    else $error("reject not flagged");
  zero_wait_a: assert property (
    !q.zeroSpeed && q.zsCnt < q.zsTime |=> !q.zeroSpeed)
    else $error("zero speed before its time");
  homing_set_a: assert property (
    drv.homingDone && !q.prevHoming |=> q.homeLatch)
    else $error("homing flag not set");

endmodule : dof_outputs

// file: testbench/dof_ctrl_model.sv
// Purpose: machine controller that watches one drive output line
// Assumes: shares mclk with the drive
// Notes:   counts rising edges so a square wave can be measured per turn
`timescale 1ns/1ps
module dof_ctrl_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched line and counter control
  input wire logic lineIn,
  input wire logic clearCount,
  output logic [7:0] riseCount
);
  logic last_q;

  // ----------------------------------------------------------------
  // edge counting
  // ----------------------------------------------------------------
  // high level is active
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
      riseCount <= 8'h00;
    end else begin
      last_q <= lineIn;
      if (clearCount) begin
        riseCount <= 8'h00;
      end else if (lineIn && !last_q) begin
        riseCount <= riseCount + 8'h01;
      end
    end
  end
endmodule : dof_ctrl_model

// file: testbench/tb_drive_digital_output_functions.sv
// Purpose: self-checking bench of the drive output routing block
// Assumes: ms tick shortened to 4 cycles
// Notes:   random drive status from a fixed xorshift seed
`timescale 1ns/1ps
module tb_drive_digital_output_functions;
  import dof_pkg::*;
  localparam int MSC = 4;
  localparam logic [31:0] NIL = 32'h0000_0000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = NIL;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  dof_drive_t drv = '0;
  logic [7:0] digIn = 8'h00;
  logic [1:0] portOut;
  logic velShiftPlus;
  logic velShiftMinus;
  logic probe1;
  logic probe2;
  logic clearCount = 1'b0;
  logic [7:0] riseCount;
  logic [31:0] seed = 32'hd688_2bd7;
  logic [31:0] rd;
  int badCount = 0;
  int samplesChecked = 0;
  logic [3:0] codes [7] = '{FN_OFF, FN_TORQUE, FN_OVERLOAD, FN_TARGET, FN_BRAKE,
                            FN_HEALTHY, FN_FIELDBUS};

  always #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;

  dof_outputs #(.NUM_OUT(2), .NUM_IN(8), .MS_CYC(MSC)) uut (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .drv(drv), .digIn(digIn), .portOut(portOut), .velShiftPlus(velShiftPlus),
    .velShiftMinus(velShiftMinus), .probe1(probe1), .probe2(probe2)
  );

  dof_ctrl_model ctrl (
    .mclk(mclk), .rst(rst), .lineIn(portOut[0]), .clearCount(clearCount),
    .riseCount(riseCount)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic exp_out(input logic [3:0] c, input dof_drive_t d, input logic fb);
    case (c)
      FN_TORQUE: return d.torqueLimit | d.ratedTorque;
      FN_OVERLOAD: return d.thermalOverloadAlarm;
      FN_TARGET: return d.posReached | d.homingDone | d.camDone | d.pressureReached;
      FN_BRAKE: return d.brakeCmd;
      FN_HEALTHY: return !d.anyAlarm;
      FN_FIELDBUS: return fb;
      default: return 1'b0;
    endcase
  endfunction : exp_out

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_w

  task automatic chk_b(input string what, input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_b

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
  endtask : step

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 20) begin
      badCount++;
      complete_run();
    end
  endtask : bus

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] c0;
    logic [3:0] c1;
    logic [31:0] fb;
    logic [31:0] r;
    logic [63:0] r64;
    dof_drive_t d;
    step(10);
    rst <= 1'b0;
    bus(1'b0, OFS_ZS_THR, NIL);
    chk_w("speed threshold", {16'h0000, ZS_THR_RST}, rd);
    bus(1'b0, OFS_ZS_TIME, NIL);
    chk_w("speed time", {16'h0000, ZS_TIME_RST}, rd);
    bus(1'b0, OFS_DIV_SHIFT, NIL);
    chk_w("divider", {27'h0000_000, DIV_SHIFT_RST}, rd);
    bus(1'b0, 8'h3C, NIL);
    chk_w("unmapped", NIL, rd);
    for (int i = 0; i < 40; i++) begin
      c0 = codes[rnd() % 7];
      c1 = codes[rnd() % 7];
      fb = rnd();
      bus(1'b1, OFS_OUT_SEL, {24'h00_0000, c1, c0});
      bus(1'b1, OFS_FIELDBUS, fb);
      bus(1'b1, OFS_CTRL_TYPE, rnd() % 7);
      r64 = {rnd(), rnd()};
      @(posedge mclk);
      drv <= dof_drive_t'(r64[42:0]);
      step(2);
      chk_b("port 0", exp_out(c0, drv, fb[0]), portOut[0]);
      chk_b("port 1", exp_out(c1, drv, fb[1]), portOut[1]);
    end
    bus(1'b1, OFS_ZS_TIME, 32'h0000_0003);
    bus(1'b1, OFS_OUT_SEL, {24'h00_0000, FN_HOMED, FN_ZERO_SPEED});
    d = '0;
    d.speedAbs = 16'h00C8;
    d.homingRequest = 1'b1;
    @(posedge mclk);
    drv <= d;
    step(3);
    chk_b("zero speed", 1'b0, portOut[0]);
    chk_b("homed", 1'b0, portOut[1]);
    d.speedAbs = ZS_THR_RST;
    d.homingRequest = 1'b0;
    d.homingDone = 1'b1;
    drv <= d;
    step(6);
    chk_b("zero speed", 1'b0, portOut[0]);
    chk_b("homed", 1'b1, portOut[1]);
    step(14);
    chk_b("zero speed", 1'b1, portOut[0]);
    bus(1'b0, OFS_OUT_STATE, NIL);
    chk_w("output state", 32'h0000_000F, rd);
    d.speedAbs = ZS_THR_RST + 16'h0001;
    d.homingDone = 1'b0;
    drv <= d;
    // flag register then port register: two edges before the port moves
    step(3);
    chk_b("zero speed", 1'b0, portOut[0]);
    chk_b("homed", 1'b1, portOut[1]);
    d.homingRequest = 1'b1;
    drv <= d;
    step(3);
    chk_b("homed", 1'b0, portOut[1]);
    // divider of 8 against a slow sweep keeps the wave far under its ceiling
    bus(1'b1, OFS_DIV_SHIFT, 32'h0000_0003);
    bus(1'b1, OFS_OUT_SEL, {24'h00_0000, FN_POS_FREQ, FN_POS_FREQ});
    @(posedge mclk);
    clearCount <= 1'b1;
    d.homingRequest = 1'b0;
    d.posInTurn = 16'h0000;
    drv <= d;
    @(posedge mclk);
    clearCount <= 1'b0;
    for (int p = 1; p <= 64; p++) begin
      d.posInTurn = p[15:0];
      drv <= d;
      @(posedge mclk);
    end
    step(3);
    chk_w("counts per turn", 64 / (2 * (1 << 3)), {24'h00_0000, riseCount});
    bus(1'b0, OFS_IRQ_STAT, NIL);
    @(posedge mclk);
    d.anyAlarm = 1'b1;
    drv <= d;
    step(3);
    chk_b("masked irq", 1'b0, irq);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001 << IRQ_ALARM);
    step(2);
    chk_b("irq", 1'b1, irq);
    bus(1'b0, OFS_IRQ_STAT, NIL);
    chk_w("alarm status", 32'h0000_0001 << IRQ_ALARM, rd & (32'h0000_0001 << IRQ_ALARM));
    step(2);
    chk_b("irq cleared", 1'b0, irq);
    bus(1'b1, OFS_PULSE_MS, 32'h0000_0002);
    bus(1'b1, OFS_OUT_SEL, {24'h00_0000, FN_OFF, FN_POS_PULSE});
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      d.posReached = 1'b0;
      d.inputStartMode = m[0];
      drv <= d;
      step(2);
      d.posReached = 1'b1;
      drv <= d;
      step(3);
      chk_b("position pulse", m[0], portOut[0]);
      step(10);
      chk_b("pulse end", 1'b0, portOut[0]);
      bus(1'b0, OFS_IRQ_STAT, NIL);
      chk_w("pulse status", (m == 1) ? (32'h0000_0001 << IRQ_POSPULSE) : NIL,
            rd & (32'h0000_0001 << IRQ_POSPULSE));
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, OFS_CTRL_TYPE, k ? {29'h0, CT_FIELDBUS} : {29'h0, CT_EAXIS});
      bus(1'b1, OFS_IN_SEL, k ? 32'h0002_0018 : 32'h0008_8000);
      for (int j = 0; j < 8; j++) begin
        r = rnd();
        @(posedge mclk);
        digIn <= r[7:0];
        step(2);
        if (k == 0) begin
          chk_b("shift plus", digIn[5], velShiftPlus);
          chk_b("shift minus", digIn[6], velShiftMinus);
        end else begin
          chk_b("probe 1", digIn[1], probe1);
          chk_b("probe 2", digIn[5], probe2);
        end
      end
    end
    bus(1'b1, OFS_CTRL_TYPE, {29'h0, CT_SPEED});
    bus(1'b0, OFS_IRQ_STAT, NIL);
    @(posedge mclk);
    digIn <= 8'hFF;
    step(2);
    chk_b("refused probe", 1'b0, probe1);
    bus(1'b0, OFS_IRQ_STAT, NIL);
    chk_w("reject status", 32'h0000_0001 << IRQ_REJECT, rd & (32'h0000_0001 << IRQ_REJECT));
    complete_run();
  end
endmodule : tb_drive_digital_output_functions
